// File: design/pcl_pkg.sv
`default_nettype none
package pcl_pkg;
  // ****************************************************************
  // Clock and link timing
  // ****************************************************************
  localparam int MCLK_PERIOD_PS = 5000;
  localparam int T_CFG_MIN_NS = 2000;
  localparam int CFG_LOW_CYCLES = (T_CFG_MIN_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int T_CF2ST_MAX_NS = 600;
  localparam int CF2ST_CYCLES = (T_CF2ST_MAX_NS * 1000) / MCLK_PERIOD_PS;
  localparam int CCLK_HALF_CYCLES = 2;
  localparam int DATA_W = 16;
  localparam int RATIO_W = 3;

  // ****************************************************************
  // Clock-to-data ratio
  // ****************************************************************
  localparam logic [RATIO_W-1:0] RATIO_ONE = 3'h1;
  localparam logic [RATIO_W-1:0] RATIO_TWO = 3'h2;
  localparam logic [RATIO_W-1:0] RATIO_FOUR = 3'h4;

  function automatic logic [RATIO_W-1:0] pcl_ratio(input logic wide16,
                                                   input logic encrypt,
                                                   input logic compress);
    logic [RATIO_W-1:0] r;
    r = RATIO_ONE;
    if (!wide16) begin
      r = compress ? RATIO_TWO : RATIO_ONE;
    end else if (compress) begin
      r = RATIO_FOUR;
    end else if (encrypt) begin
      r = RATIO_TWO;
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// File: design/pcl_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcl_link_if;
  import pcl_pkg::*;
  logic              config_clock;
  logic [DATA_W-1:0] config_data;
  logic              config_request_n;
  logic              config_status_n;
  logic              config_complete;
  logic              mode_wide16;
  logic              mode_encrypt;
  logic              mode_compress;

  modport host (
    output config_clock, config_data, config_request_n,
    output mode_wide16, mode_encrypt, mode_compress,
    input  config_status_n, config_complete
  );
  modport device (
    input  config_clock, config_data, config_request_n,
    input  mode_wide16, mode_encrypt, mode_compress,
    output config_status_n, config_complete
  );
endinterface
`default_nettype wire

// File: design/pcl_host.sv
// What this block does
// - Host clock rate is ratio times word rate
// - Byte bus: ratio one, two when compressed
// - Word bus: one, two encrypted, four compressed
// - Complete drops within 600 ns of request
// - Status drops within 600 ns of request
// - Host holds request low at least 2 us
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Word buffer
// ****************************************************************
module pcl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;
  logic             full_q, full_d;

  assign in_ready  = !full_q;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d  = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d  = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
    full_d = (cnt_d == (AW+1)'(DEPTH));
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (push && !flush) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // pcl_fifo

// ****************************************************************
// Configuration host
// ****************************************************************
module pcl_host #(
  parameter int FIFO_DEPTH = 16,
  parameter int LOW_CYCLES = pcl_pkg::CFG_LOW_CYCLES
) (
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  pcl_link_if.host                         link,
  input  wire logic                        start,
  input  wire logic                        wide16,
  input  wire logic                        encrypt,
  input  wire logic                        compress,
  input  wire logic [pcl_pkg::DATA_W-1:0]  word_data,
  input  wire logic                        word_valid,
  output logic                             word_ready,
  output logic                             busy,
  output logic                             done
);
  import pcl_pkg::*;

  typedef enum logic [2:0] {PCL_IDLE, PCL_PULSE, PCL_WAIT, PCL_SEND, PCL_DONE} pcl_state_t;

  pcl_state_t         st_q, st_d;
  logic [15:0]        cyc_q, cyc_d;
  logic               clk_q, clk_d;
  logic [DATA_W-1:0]  dat_q, dat_d;
  logic [RATIO_W-1:0] left_q, left_d;
  logic               have_q, have_d;
  logic               req_n_q, req_n_d;
  logic               wide_q, wide_d, enc_q, enc_d, cmp_q, cmp_d;
  logic               busy_q, busy_d, done_q, done_d;
  logic               fifo_ready, fifo_valid, pop;
  logic [DATA_W-1:0]  fifo_data;

  pcl_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .flush     (start),
    .in_data   (word_data),
    .in_valid  (word_valid),
    .in_ready  (fifo_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );

  assign word_ready = fifo_ready;

  always_comb begin
    st_d    = st_q;
    cyc_d   = cyc_q;
    clk_d   = clk_q;
    dat_d   = dat_q;
    left_d  = left_q;
    have_d  = have_q;
    req_n_d = req_n_q;
    wide_d  = wide_q;
    enc_d   = enc_q;
    cmp_d   = cmp_q;
    done_d  = done_q;
    pop     = 1'b0;
    case (st_q)
      PCL_IDLE, PCL_DONE: begin
        if (start) begin
          wide_d  = wide16;
          enc_d   = encrypt;
          cmp_d   = compress;
          req_n_d = 1'b0;
          cyc_d   = 16'(LOW_CYCLES - 1);
          done_d  = 1'b0;
          clk_d   = 1'b0;
          have_d  = 1'b0;
          st_d    = PCL_PULSE;
        end
      end
      PCL_PULSE: begin
        if (cyc_q == '0) begin
          req_n_d = 1'b1;
          st_d    = PCL_WAIT;
        end else begin
          cyc_d = cyc_q - 16'h0001;
        end
      end
      PCL_WAIT: begin
        if (link.config_status_n) begin
          cyc_d = '0;
          st_d  = PCL_SEND;
        end
      end
      PCL_SEND: begin
        if (link.config_complete) begin
          clk_d  = 1'b0;
          done_d = 1'b1;
          st_d   = PCL_DONE;
        end else if (cyc_q != '0) begin
          cyc_d = cyc_q - 16'h0001;
        end else if (!clk_q) begin
          if (have_q) begin
            clk_d = 1'b1;
            cyc_d = 16'(CCLK_HALF_CYCLES - 1);
          end else if (fifo_valid) begin
            pop    = 1'b1;
            dat_d  = fifo_data;
            left_d = pcl_ratio(wide_q, enc_q, cmp_q);
            have_d = 1'b1;
            cyc_d  = 16'(CCLK_HALF_CYCLES - 1);
          end
        end else begin
          clk_d  = 1'b0;
          cyc_d  = 16'(CCLK_HALF_CYCLES - 1);
          left_d = left_q - 1'b1;
          if (left_q == RATIO_ONE) begin
            have_d = 1'b0;
          end
        end
      end
      default: begin
        st_d = PCL_IDLE;
      end
    endcase
    busy_d = (st_d != PCL_IDLE) && (st_d != PCL_DONE);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q    <= PCL_IDLE;
      cyc_q   <= '0;
      clk_q   <= 1'b0;
      dat_q   <= '0;
      left_q  <= '0;
      have_q  <= 1'b0;
      req_n_q <= 1'b1;
      wide_q  <= 1'b0;
      enc_q   <= 1'b0;
      cmp_q   <= 1'b0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      cyc_q   <= cyc_d;
      clk_q   <= clk_d;
      dat_q   <= dat_d;
      left_q  <= left_d;
      have_q  <= have_d;
      req_n_q <= req_n_d;
      wide_q  <= wide_d;
      enc_q   <= enc_d;
      cmp_q   <= cmp_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
    end
  end

  assign link.config_clock     = clk_q;
  assign link.config_data      = dat_q;
  assign link.config_request_n = req_n_q;
  assign link.mode_wide16      = wide_q;
  assign link.mode_encrypt     = enc_q;
  assign link.mode_compress    = cmp_q;
  assign busy                  = busy_q;
  assign done                  = done_q;
endmodule // pcl_host
`default_nettype wire

// File: design/pcl_device.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Configuration device port
// ****************************************************************
module pcl_device (
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  pcl_link_if.device                       link,
  input  wire logic                        load_done,
  output logic [pcl_pkg::DATA_W-1:0]       word_data,
  output logic                             word_valid,
  output logic                             in_config
);
  import pcl_pkg::*;

  typedef enum logic [1:0] {PCL_CLEAR, PCL_LOAD, PCL_COMPLETE} pcl_dev_state_t;

  pcl_dev_state_t     st_q, st_d;
  logic               cclk_q, cclk_d;
  logic [RATIO_W-1:0] edges_q, edges_d;
  logic [DATA_W-1:0]  word_q, word_d;
  logic               wvalid_q, wvalid_d;
  logic               status_n_q, status_n_d;
  logic               complete_q, complete_d;
  logic [RATIO_W-1:0] ratio;
  logic               rise;
  logic               in_config_q, in_config_d;

  assign ratio = pcl_ratio(link.mode_wide16, link.mode_encrypt, link.mode_compress);
  assign rise  = link.config_clock && !cclk_q;

  always_comb begin
    st_d       = st_q;
    cclk_d     = link.config_clock;
    edges_d    = edges_q;
    word_d     = word_q;
    wvalid_d   = 1'b0;
    status_n_d = status_n_q;
    complete_d = complete_q;
    if (!link.config_request_n) begin
      st_d       = PCL_CLEAR;
      status_n_d = 1'b0;
      complete_d = 1'b0;
      edges_d    = '0;
    end else begin
      case (st_q)
        PCL_CLEAR: begin
          status_n_d = 1'b1;
          st_d       = PCL_LOAD;
        end
        PCL_LOAD: begin
          if (load_done) begin
            complete_d = 1'b1;
            st_d       = PCL_COMPLETE;
          end else if (rise) begin
            if (edges_q + 1'b1 >= ratio) begin
              edges_d  = '0;
              wvalid_d = 1'b1;
              word_d   = link.mode_wide16 ? link.config_data
                                          : {8'h00, link.config_data[7:0]};
            end else begin
              edges_d = edges_q + 1'b1;
            end
          end
        end
        PCL_COMPLETE: begin
          complete_d = 1'b1;
        end
        default: begin
          st_d = PCL_CLEAR;
        end
      endcase
    end
    in_config_d = status_n_d && !complete_d;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q       <= PCL_CLEAR;
      cclk_q     <= 1'b0;
      edges_q    <= '0;
      word_q     <= '0;
      wvalid_q   <= 1'b0;
      status_n_q <= 1'b0;
      complete_q <= 1'b0;
      in_config_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      cclk_q     <= cclk_d;
      edges_q    <= edges_d;
      word_q     <= word_d;
      wvalid_q   <= wvalid_d;
      status_n_q <= status_n_d;
      complete_q <= complete_d;
      in_config_q <= in_config_d;
    end
  end

  assign link.config_status_n = status_n_q;
  assign link.config_complete = complete_q;
  assign word_data            = word_q;
  assign word_valid           = wvalid_q;
  assign in_config            = in_config_q;
endmodule // pcl_device
`default_nettype wire

// File: dv/pcl_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pcl_link_asserts #(
  parameter int LOW_CYCLES = pcl_pkg::CFG_LOW_CYCLES
) (
  input wire logic                       mclk,
  input wire logic                       resetn,
  input wire logic                       config_clock,
  input wire logic [pcl_pkg::DATA_W-1:0] config_data,
  input wire logic                       config_request_n,
  input wire logic                       config_status_n,
  input wire logic                       config_complete,
  input wire logic                       mode_wide16,
  input wire logic                       mode_encrypt,
  input wire logic                       mode_compress
);
  import pcl_pkg::*;
  localparam int STW = CF2ST_CYCLES;
  logic [8:0]        low_q, low_d;
  logic [3:0]        cnt_q, cnt_d;
  logic              clk_q, clk_d;
  logic [DATA_W-1:0] dat_q, dat_d;
  logic [3:0]        ratio;

  // ****************************************************************
  // Helper counters
  // ****************************************************************
  assign ratio = mode_wide16 ? (mode_compress ? 4'h4 : mode_encrypt ? 4'h2 : 4'h1)
                             : (mode_compress ? 4'h2 : 4'h1);
  always_comb begin
    low_d = config_request_n ? 9'h000 : low_q + 9'h001;
    clk_d = config_clock;
    dat_d = config_data;
    cnt_d = cnt_q;
    if (!config_request_n || config_data != dat_q) begin
      cnt_d = 4'h0;
    end else if (config_clock && !clk_q) begin
      cnt_d = cnt_q + 4'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      {low_q, cnt_q, clk_q, dat_q} <= '0;
    end else begin
      {low_q, cnt_q, clk_q, dat_q} <= {low_d, cnt_d, clk_d, dat_d};
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence clk_high_two;
    config_clock [*2];
  endsequence
  sequence clk_then_low;
    clk_high_two ##1 !config_clock;
  endsequence

  chk_status_drop: assert property ($fell(config_request_n) |-> ##[1:STW] !config_status_n)
    else $error("status did not drop after request");
  chk_complete_drop: assert property ($fell(config_request_n) |-> ##[1:STW] !config_complete)
    else $error("complete did not drop after request");
  chk_request_width: assert property ($rose(config_request_n) |-> low_q == LOW_CYCLES)
    else $error("request low pulse has wrong width");
  chk_stat_low_hold: assert property (!config_request_n && !$past(config_request_n)
    |-> !config_status_n && !config_complete) else $error("status or complete high in request");
  chk_word_ratio: assert property (config_data != dat_q && cnt_q != 4'h0
    |-> cnt_q == ratio) else $error("word held for wrong number of clock rises");
  chk_clock_shape: assert property ($rose(config_clock) |-> clk_then_low)
    else $error("configuration clock high time wrong");
  chk_clock_gate: assert property ($rose(config_clock)
    |-> config_status_n && config_request_n) else $error("clock ran before device ready");
  chk_mode_stable: assert property (config_clock
    |-> $stable({mode_wide16, mode_encrypt, mode_compress}))
    else $error("mode changed during a transfer");
endmodule // pcl_link_asserts
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcl_pkg::*;
  localparam int LOWC = 4;
  typedef struct {logic w; logic e; logic c; int r;} pcl_row_t;
  pcl_row_t rows [8] = '{'{0, 0, 0, 1}, '{0, 1, 0, 1}, '{0, 0, 1, 2}, '{0, 1, 1, 2},
                         '{1, 0, 0, 1}, '{1, 1, 0, 2}, '{1, 0, 1, 4}, '{1, 1, 1, 4}};
  logic              mclk, resetn, start, wide16, encrypt, compress, word_valid, load_done;
  logic              word_ready, busy, done, dev_valid, in_config;
  logic [DATA_W-1:0] word_data, dev_data;
  logic [DATA_W-1:0] rx [$];
  int                fails, compares, rises, k;

  pcl_link_if pcl_link_if_inst ();
  pcl_host #(.FIFO_DEPTH(16), .LOW_CYCLES(LOWC)) pcl_host_inst (.mclk(mclk), .resetn(resetn),
    .link(pcl_link_if_inst.host), .start(start), .wide16(wide16), .encrypt(encrypt),
    .compress(compress), .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready), .busy(busy), .done(done));
  pcl_device pcl_device_inst (.mclk(mclk), .resetn(resetn), .link(pcl_link_if_inst.device),
    .load_done(load_done), .word_data(dev_data), .word_valid(dev_valid), .in_config(in_config));
  pcl_link_asserts #(.LOW_CYCLES(LOWC)) pcl_link_asserts_inst (.mclk(mclk), .resetn(resetn),
    .config_clock(pcl_link_if_inst.config_clock), .config_data(pcl_link_if_inst.config_data),
    .config_request_n(pcl_link_if_inst.config_request_n),
    .config_status_n(pcl_link_if_inst.config_status_n),
    .config_complete(pcl_link_if_inst.config_complete),
    .mode_wide16(pcl_link_if_inst.mode_wide16), .mode_encrypt(pcl_link_if_inst.mode_encrypt),
    .mode_compress(pcl_link_if_inst.mode_compress));

  // ****************************************************************
  // Clock, monitors and helpers
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge pcl_link_if_inst.config_clock) rises++;
  always @(posedge mclk) if (dev_valid === 1'b1) rx.push_back(dev_data);

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic push_words(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      word_data <= DATA_W'(base + i);
      word_valid <= 1'b1;
      @(posedge mclk);
    end
    word_valid <= 1'b0;
  endtask
  task automatic pulse_start();
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
  endtask
  // One full load: start (which flushes the buffer), feed sixteen words, drain, finish
  task automatic run_row(input pcl_row_t row, input int base);
    wide16 <= row.w;
    encrypt <= row.e;
    compress <= row.c;
    rx.delete();
    rises = 0;
    pulse_start();
    repeat (2) @(posedge mclk);
    #1 check("complete", 1'b0, pcl_link_if_inst.config_complete);
    check("status_n", 1'b0, pcl_link_if_inst.config_status_n);
    @(posedge mclk);
    push_words(16, base);
    for (k = 0; k < 2000 && rx.size() < 16; k++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    #1 check("rises", 32'(16 * row.r), 32'(rises));
    check("rx count", 32'd16, 32'(rx.size()));
    foreach (rx[i]) begin
      check("rx word", 32'(row.w ? base + i : (base + i) % 256), 32'(rx[i]));
    end
    @(posedge mclk);
    load_done <= 1'b1;
    for (k = 0; k < 50 && done !== 1'b1; k++) @(posedge mclk);
    #1 check("done", 1'b1, done);
    check("busy", 1'b0, busy);
    @(posedge mclk);
    load_done <= 1'b0;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    {resetn, start, wide16, encrypt, compress, word_valid, load_done} = '0;
    word_data = '0;
    {fails, compares, rises} = '0;
    repeat (10) @(posedge mclk);
    #1 check("reset status_n", 1'b0, pcl_link_if_inst.config_status_n);
    check("reset request_n", 1'b1, pcl_link_if_inst.config_request_n);
    @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 check("in_config", 1'b1, in_config);
    @(posedge mclk);
    foreach (rows[i]) run_row(rows[i], 16'h5A00 + i * 32);
    push_words(17, 8'hF0);
    #1 check("full ready", 1'b0, word_ready);
    @(posedge mclk);
    pulse_start();
    #1 check("flush ready", 1'b1, word_ready);
    @(posedge mclk);
    push_words(4, 8'hE0);
    repeat (6) @(posedge mclk);
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 check("mid status_n", 1'b0, pcl_link_if_inst.config_status_n);
    check("mid complete", 1'b0, pcl_link_if_inst.config_complete);
    check("mid clock", 1'b0, pcl_link_if_inst.config_clock);
    check("mid busy", 1'b0, busy);
    check("mid ready", 1'b1, word_ready);
    @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 check("status_n again", 1'b1, pcl_link_if_inst.config_status_n);
    tally_and_finish();
  end
  // Whole run is under two thousand cycles; this leaves a wide margin
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
